/* File: design/watchdog_consts.svh */
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// ************************************************************
// bus geometry
// ************************************************************
`define WDT_ADR_W          8
`define WDT_DAT_W          32
`define WDT_BYTE_W         8
`define WDT_IDX_W          8
`define WDT_SEL_W          4

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define WDT_IDX_CONFIG     8'h34
`define WDT_IDX_CODE       8'h35
`define WDT_IDX_STATUS     8'h36

// ************************************************************
// control codes written to the code register
// ************************************************************
`define WDT_CODE_CLEAR     8'h4e
`define WDT_CODE_DISABLE   8'hb1

// ************************************************************
// configuration fields and reset values
// ************************************************************
`define WDT_CFG_EN_BIT     3
`define WDT_CFG_TIME_HI    2
`define WDT_CFG_TIME_LO    1
`define WDT_CFG_ACT_BIT    0
`define WDT_RST_EN         1'b1
`define WDT_RST_TIME       2'h0
`define WDT_RST_ACT        1'b1
`define WDT_ACT_IRQ        1'b0
`define WDT_ACT_RESET      1'b1

// ************************************************************
// status fields
// ************************************************************
`define WDT_ST_ACTIVE      0
`define WDT_ST_EN_BIT      1
`define WDT_ST_ACT_BIT     2
`define WDT_ST_TIME_LO     3
`define WDT_ST_TIME_HI     4
`define WDT_ST_BIN_LO      5
`define WDT_ST_BIN_HI      6
`define WDT_ST_OVF         7

// ************************************************************
// timing
// ************************************************************
`define WDT_FC_EXP         25
`define WDT_FS_EXP         17
`define WDT_EXP_STEP       2
`define WDT_BIN_EXP        2
`define WDT_BIN_TOP        2'h3
`define WDT_RST_HOLD_FC    24
`define WDT_HOLD_W         5
`define WDT_TAP_W          5
`define WDT_DIV_W          24

`endif

/* File: design/watchdog_pkg.sv */
`include "watchdog_consts.svh"

package watchdog_pkg;

    // ************************************************************
    // reset pin sequencer, one-hot
    // ************************************************************
    typedef enum logic [1:0] {
        ST_RUN     = 2'b01,
        ST_RST_OUT = 2'b10
    } rst_fsm_t;

    // ************************************************************
    // software visible configuration
    // ************************************************************
    typedef struct packed {
        logic       en_bit;
        logic [1:0] detect_time_sel;
        logic       overflow_action_sel;
    } wdt_cfg_t;

    // ************************************************************
    // whole state of the top module
    // ************************************************************
    typedef struct packed {
        wdt_cfg_t                  cfg;
        logic                      active;
        logic [1:0]                bin_cnt;
        logic                      ovf_seen;
        rst_fsm_t                  fsm;
        logic [`WDT_HOLD_W-1:0]    hold_cnt;
        logic [2:0]                fs_sync;
        logic                      ack;
        logic [`WDT_DAT_W-1:0]     rdata;
        logic                      irq;
        logic                      rst_req;
        logic                      pin_oe;
    } wdt_state_t;

    // ************************************************************
    // divider state
    // ************************************************************
    typedef struct packed {
        logic [`WDT_DIV_W-1:0] cnt;
    } div_state_t;

endpackage

/* File: design/wd_divider.sv */
`timescale 1ns/1ps
`include "watchdog_consts.svh"

module wd_divider #(
    parameter int DIV_W = `WDT_DIV_W
) (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // control
    input  wire logic                  step_i,
    input  wire logic [`WDT_TAP_W-1:0] tap_i,
    // output
    output      logic                  tick_o
);

    // ************************************************************
    // elaboration check
    // ************************************************************
    if (DIV_W < 2 || DIV_W > 31) begin : g_chk
        $error("wd_divider: DIV_W out of range");
    end

    watchdog_pkg::div_state_t st_q;
    watchdog_pkg::div_state_t st_d;
    logic [DIV_W-1:0]         mask;

    // free running, never cleared by software
    always_comb begin
        st_d = st_q;
        mask = ~({DIV_W{1'b1}} << tap_i);
        if (step_i) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    // tick when the selected low bits wrap
    assign tick_o = step_i && ((st_q.cnt & mask) == mask);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

/* File: design/watchdog_timer_unit.sv */
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "watchdog_consts.svh"

// Functional notes
// - counting starts at reset release, enable set
// - reset action after reset, changeable only once
// - overflow with select one: reset, pin low
// - overflow with select zero: interrupt request
// - halt in stop, warm-up, idle, sleep
// - clear code resets binary counter only
// - shortest overflow is three quarters of time
// - bit 3 enables; zero needs disable code
// - bits 2:1 select detection time per source
// - bit 0: zero interrupt, one reset
// - select bit cannot return to one
// - configuration write-only, no read-modify-write
// - disable code valid only with enable zero
// - overflow usable as periodic interrupt
// - binary counter held clear while disabled
// - interrupt non-maskable, ignores master flag

module watchdog_timer_unit #(
    parameter int FC_EXP = `WDT_FC_EXP,
    parameter int FS_EXP = `WDT_FS_EXP,
    parameter int DIV_W  = `WDT_DIV_W
) (
    // clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // wishbone classic slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [`WDT_ADR_W-1:0] wb_adr_i,
    input  wire logic [`WDT_SEL_W-1:0] wb_sel_i,
    input  wire logic [`WDT_DAT_W-1:0] wb_dat_i,
    output      logic [`WDT_DAT_W-1:0] wb_dat_o,
    output      logic                  wb_ack_o,
    // clock source and operating mode
    input  wire logic                  fs_clk_i,
    input  wire logic                  prescaler_clock_sel_i,
    input  wire logic                  slow_mode_i,
    input  wire logic                  stop_mode_i,
    input  wire logic                  warmup_i,
    input  wire logic                  idle_sleep_i,
    // overflow requests
    output      logic                  wd_interrupt_req_o,
    output      logic                  wd_reset_req_o,
    // reset pin, open drain
    output      logic                  reset_pin_o,
    output      logic                  reset_pin_oe_o
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    localparam int MIN_TAP = FS_EXP - 3 * `WDT_EXP_STEP - `WDT_BIN_EXP;

    if (MIN_TAP < 1) begin : g_chk_fs
        $error("watchdog_timer_unit: FS_EXP too small");
    end
    if (FC_EXP - `WDT_BIN_EXP > DIV_W || FS_EXP - `WDT_BIN_EXP > DIV_W) begin : g_chk_w
        $error("watchdog_timer_unit: divider narrower than tap");
    end
    if (FC_EXP - 3 * `WDT_EXP_STEP - `WDT_BIN_EXP < 1) begin : g_chk_fc
        $error("watchdog_timer_unit: FC_EXP too small");
    end

    // ************************************************************
    // constants
    // ************************************************************
    localparam logic [`WDT_HOLD_W-1:0] HOLD_CYC = `WDT_HOLD_W'(`WDT_RST_HOLD_FC);

    localparam watchdog_pkg::wdt_state_t RESET_STATE = '{
        cfg      : '{en_bit              : `WDT_RST_EN,
                     detect_time_sel     : `WDT_RST_TIME,
                     overflow_action_sel : `WDT_RST_ACT},
        active   : 1'b1,
        bin_cnt  : '0,
        ovf_seen : 1'b0,
        fsm      : watchdog_pkg::ST_RUN,
        hold_cnt : '0,
        fs_sync  : '0,
        ack      : 1'b0,
        rdata    : '0,
        irq      : 1'b0,
        rst_req  : 1'b0,
        pin_oe   : 1'b0
    };

    // ************************************************************
    // decoding helpers
    // ************************************************************

    // byte address of a register index
    function automatic logic reg_hit(input logic [`WDT_ADR_W-1:0] adr,
                                     input logic [`WDT_IDX_W-1:0] idx);
        logic [`WDT_IDX_W+1:0] byte_adr;
        byte_adr = {idx, 2'b00};
        reg_hit  = ({2'b00, adr} == byte_adr);
    endfunction

    // number of divider bits below one binary counter step
    function automatic logic [`WDT_TAP_W-1:0] tap_of(input int base,
                                                     input logic [1:0] sel);
        int e;
        e      = base - `WDT_BIN_EXP - `WDT_EXP_STEP * int'(sel);
        tap_of = `WDT_TAP_W'(e);
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    watchdog_pkg::wdt_state_t st_q;
    watchdog_pkg::wdt_state_t st_d;

    logic                  halt;
    logic                  use_fs;
    logic                  fs_edge;
    logic                  div_step;
    logic [`WDT_TAP_W-1:0] div_tap;
    logic                  div_tick;
    logic                  bus_req;
    logic                  wr_byte;
    logic [`WDT_BYTE_W-1:0] wbyte;
    logic                  bin_clr;
    logic                  overflow;

    // ************************************************************
    // clock source selection and halting
    // ************************************************************

    // stop mode covers its warm-up too
    assign halt    = stop_mode_i || warmup_i || idle_sleep_i;
    assign use_fs  = prescaler_clock_sel_i || slow_mode_i;
    // edge from the second and third sync stages only
    assign fs_edge = st_q.fs_sync[1] && !st_q.fs_sync[2];

    // fc source is the block clock itself, fs is counted by edges
    assign div_step = !halt && (use_fs ? fs_edge : 1'b1);

    // tap picks one quarter of the detection time
    assign div_tap = use_fs ? tap_of(FS_EXP, st_q.cfg.detect_time_sel)
                            : tap_of(FC_EXP, st_q.cfg.detect_time_sel);

    // ************************************************************
    // internal divider
    // ************************************************************

    // never cleared by the clear code, so the phase survives a clear
    wd_divider #(
        .DIV_W (DIV_W)
    ) u_div (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .step_i  (div_step),
        .tap_i   (div_tap),
        .tick_o  (div_tick)
    );

    // ************************************************************
    // bus decode
    // ************************************************************

    // ack is registered, so a held request is taken only once
    assign bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
    // registers live in byte lane 0 only
    assign wr_byte = bus_req && wb_we_i && wb_sel_i[0];
    assign wbyte   = wb_dat_i[`WDT_BYTE_W-1:0];

    // clear code, other values fall through untouched
    assign bin_clr = wr_byte && reg_hit(wb_adr_i, `WDT_IDX_CODE)
                     && (wbyte == `WDT_CODE_CLEAR);

    // fourth quarter tick of the binary counter
    assign overflow = st_q.active && !bin_clr && div_tick
                      && (st_q.bin_cnt == `WDT_BIN_TOP);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_d         = st_q;
        st_d.ack     = 1'b0;
        st_d.irq     = 1'b0;
        st_d.rst_req = 1'b0;
        st_d.fs_sync = {st_q.fs_sync[1:0], fs_clk_i};

        // bus access
        if (bus_req) begin
            st_d.ack   = 1'b1;
            st_d.rdata = '0;
            if (wr_byte && reg_hit(wb_adr_i, `WDT_IDX_CONFIG)) begin
                st_d.cfg.detect_time_sel = wbyte[`WDT_CFG_TIME_HI:`WDT_CFG_TIME_LO];
                // once cleared the select bit stays cleared
                st_d.cfg.overflow_action_sel = st_q.cfg.overflow_action_sel
                                               & wbyte[`WDT_CFG_ACT_BIT];
                if (wbyte[`WDT_CFG_EN_BIT]) begin
                    st_d.cfg.en_bit = 1'b1;
                    st_d.active     = 1'b1;
                end else begin
                    // a zero only arms the disable code
                    st_d.cfg.en_bit = 1'b0;
                end
            end
            if (wr_byte && reg_hit(wb_adr_i, `WDT_IDX_CODE)) begin
                if (wbyte == `WDT_CODE_DISABLE && !st_q.cfg.en_bit) begin
                    st_d.active = 1'b0;
                end
            end
            if (wr_byte && reg_hit(wb_adr_i, `WDT_IDX_STATUS) && wbyte[`WDT_ST_OVF]) begin
                st_d.ovf_seen = 1'b0;
            end
            // configuration and code read as zero, nothing to modify
            if (!wb_we_i && reg_hit(wb_adr_i, `WDT_IDX_STATUS)) begin
                st_d.rdata[`WDT_ST_ACTIVE]                = st_q.active;
                st_d.rdata[`WDT_ST_EN_BIT]                = st_q.cfg.en_bit;
                st_d.rdata[`WDT_ST_ACT_BIT]               = st_q.cfg.overflow_action_sel;
                st_d.rdata[`WDT_ST_TIME_HI:`WDT_ST_TIME_LO] = st_q.cfg.detect_time_sel;
                st_d.rdata[`WDT_ST_BIN_HI:`WDT_ST_BIN_LO]   = st_q.bin_cnt;
                st_d.rdata[`WDT_ST_OVF]                   = st_q.ovf_seen;
            end
        end

        // binary counter
        if (!st_q.active || bin_clr) begin
            st_d.bin_cnt = '0;
        end else if (div_tick) begin
            st_d.bin_cnt = st_q.bin_cnt + 2'h1; // wraps to zero at overflow
        end

        // overflow routing, one pulse per event
        if (overflow) begin
            st_d.ovf_seen = 1'b1; // set wins over a same-cycle clear
            if (st_q.cfg.overflow_action_sel == `WDT_ACT_RESET) begin
                st_d.rst_req  = 1'b1;
                st_d.pin_oe   = 1'b1;
                st_d.hold_cnt = HOLD_CYC;
                st_d.fsm      = watchdog_pkg::ST_RST_OUT;
            end else begin
                // no master flag input: cannot be masked
                st_d.irq = 1'b1;
            end
        end

        // reset pin low time
        case (st_q.fsm)
            watchdog_pkg::ST_RUN: begin
                if (!overflow) begin
                    st_d.pin_oe = 1'b0;
                end
            end
            watchdog_pkg::ST_RST_OUT: begin
                if (!overflow) begin
                    if (st_q.hold_cnt <= `WDT_HOLD_W'(1)) begin
                        st_d.pin_oe = 1'b0;
                        st_d.fsm    = watchdog_pkg::ST_RUN;
                    end else begin
                        st_d.hold_cnt = st_q.hold_cnt - `WDT_HOLD_W'(1);
                    end
                end
            end
            default: begin
                st_d.fsm    = watchdog_pkg::ST_RUN;
                st_d.pin_oe = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************

    // reset leaves the watchdog running with reset action
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            st_q <= RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_dat_o           = st_q.rdata;
    assign wb_ack_o           = st_q.ack;
    assign wd_interrupt_req_o = st_q.irq;
    assign wd_reset_req_o     = st_q.rst_req;
    // open drain: only ever pulls low
    assign reset_pin_o        = 1'b0;
    assign reset_pin_oe_o     = st_q.pin_oe;

endmodule

/* File: testbench/watchdog_timer_unit_asserts.sv */
`timescale 1ns/1ps
`include "watchdog_consts.svh"

module watchdog_timer_unit_asserts (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // modes
    input wire logic        stop_mode_i,
    input wire logic        warmup_i,
    input wire logic        idle_sleep_i,
    // requests and pin
    input wire logic        wd_interrupt_req_o,
    input wire logic        wd_reset_req_o,
    input wire logic        reset_pin_o,
    input wire logic        reset_pin_oe_o
);
    // **********
    // shadow state
    // **********
    logic       take;
    logic       en_q;
    logic       act_q;
    logic       sel_q;
    logic [5:0] since_q;
    logic       halt;
    logic       req;
    assign take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign halt = stop_mode_i | warmup_i | idle_sleep_i;
    assign req  = wd_interrupt_req_o | wd_reset_req_o;
    // enable, run state, route and age of the last reset request
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            en_q    <= 1'b1;
            act_q   <= 1'b1;
            sel_q   <= 1'b1;
            since_q <= 6'h3f;
        end else begin
            if (take && wb_adr_i == 8'hd0) begin
                en_q  <= wb_dat_i[3];
                sel_q <= sel_q & wb_dat_i[0];
                if (wb_dat_i[3]) act_q <= 1'b1;
            end
            if (take && wb_adr_i == 8'hd4 && wb_dat_i[7:0] == `WDT_CODE_DISABLE && !en_q) act_q <= 1'b0;
            // saturates so an old request never looks fresh
            if (wd_reset_req_o) since_q <= 6'h01;
            else if (since_q != 6'h3f) since_q <= since_q + 6'h01;
        end
    end

    // **********
    // properties
    // **********
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    chk_ack_answer: assert property ($rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o) else $error("no ack");
    chk_wo_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 8'hd8 |-> wb_dat_o == '0)
        else $error("write-only read not zero");
    chk_req_onehot: assert property (!(wd_interrupt_req_o && wd_reset_req_o)) else $error("both routes");
    chk_irq_pulse: assert property (wd_interrupt_req_o |=> !wd_interrupt_req_o) else $error("irq wide");
    chk_rst_pulse: assert property (wd_reset_req_o |=> !wd_reset_req_o) else $error("reset req wide");
    chk_irq_route: assert property (wd_interrupt_req_o |-> !sel_q) else $error("irq with reset route");
    chk_rst_route: assert property (wd_reset_req_o |-> $past(sel_q)) else $error("reset after irq route");
    chk_pin_low: assert property (reset_pin_oe_o |-> !reset_pin_o) else $error("pin not low");
    chk_pin_hold: assert property (since_q inside {[6'd2:6'd23]} |-> reset_pin_oe_o) else $error("pin short");
    chk_pin_release: assert property (reset_pin_oe_o && !wd_reset_req_o |-> since_q <= 6'd24) else $error("pin long");
    chk_halt_quiet: assert property (halt [*3] |=> !req) else $error("overflow while halted");
    chk_off_quiet: assert property ((!act_q) [*3] |-> !req) else $error("overflow while off");

    cover property (wd_interrupt_req_o);
    cover property (wd_reset_req_o);
    cover property ($fell(reset_pin_oe_o));
    cover property (!act_q ##1 act_q);
endmodule

bind watchdog_timer_unit watchdog_timer_unit_asserts chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .stop_mode_i(stop_mode_i), .warmup_i(warmup_i), .idle_sleep_i(idle_sleep_i),
    .wd_interrupt_req_o(wd_interrupt_req_o), .wd_reset_req_o(wd_reset_req_o),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o)
);

/* File: testbench/watchdog_timer_unit_test.sv */
`timescale 1ns/1ps
`include "watchdog_consts.svh"

module watchdog_timer_unit_test;
    // **********
    // stimulus and observation
    // **********
    localparam int FCX = 10;
    localparam int FSX = 9;
    localparam logic [7:0] a_cfg  = 8'(`WDT_IDX_CONFIG * 4);
    localparam logic [7:0] a_code = 8'(`WDT_IDX_CODE * 4);
    localparam logic [7:0] a_stat = 8'(`WDT_IDX_STATUS * 4);
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = '0;
    logic [31:0] dat_w = '0;
    logic [31:0] dat_r;
    logic        ack;
    logic [1:0]  fs_div = '0;
    logic        psel = 1'b0;
    logic        slow = 1'b0;
    logic [2:0]  halt = '0;
    logic        irq;
    logic        rreq;
    logic        pin;
    logic        pin_oe;
    int          error_cnt = 0;
    int          checked = 0;
    int          now = 0;
    int          irq_seen = 0;
    int          rst_seen = 0;

    always #50 clock_i = ~clock_i;
    // cycle count, pulse tallies, slow clock of four cycles
    always @(posedge clock_i) begin
        now <= now + 1;
        irq_seen <= irq_seen + int'(irq === 1'b1);
        rst_seen <= rst_seen + int'(rreq === 1'b1);
        fs_div <= fs_div + 2'h1;
    end

    watchdog_timer_unit #(.FC_EXP(FCX), .FS_EXP(FSX)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .fs_clk_i(fs_div[1]), .prescaler_clock_sel_i(psel), .slow_mode_i(slow), .stop_mode_i(halt[2]),
        .warmup_i(halt[1]), .idle_sleep_i(halt[0]), .wd_interrupt_req_o(irq), .wd_reset_req_o(rreq),
        .reset_pin_o(pin), .reset_pin_oe_o(pin_oe)
    );

    // **********
    // shared tasks
    // **********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    // classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clock_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        check(n < 50, 1'b1, "ack timeout");
        r = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    // edges until the chosen request is sampled high
    task automatic wait_req(input logic rs, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while ((rs ? rreq : irq) !== 1'b1 && n < lim);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // **********
    // scenarios
    // **********
    task automatic t_reset_route();
        logic [31:0] r;
        int n;
        int r0;
        bus(1'b0, a_stat, 8'h0, r);
        check(r, 32'h07, "status after reset");
        bus(1'b0, a_cfg, 8'h0, r);
        check(r, 32'h0, "config read");
        wr(8'h10, 8'hff);
        bus(1'b0, 8'h10, 8'h0, r);
        check(r, 32'h0, "unmapped read");
        wait_req(1'b1, 1100, n);
        check(n inside {[900:1024]}, 1'b1, "first overflow");
        repeat (2) @(posedge clock_i);
        check({pin_oe, pin, irq_seen[0]}, 3'b100, "reset pin");
        wr(a_cfg, 8'h0f);
        wait_req(1'b1, 40, n);
        wait_req(1'b1, 40, n);
        check(n, 16, "reset period");
        wr(a_cfg, 8'h0e);
        r0 = rst_seen;
        wr(a_cfg, 8'h0f);
        bus(1'b0, a_stat, 8'h0, r);
        check(r[4:0], 5'h1b, "select stuck at zero");
        wait_req(1'b0, 40, n);
        wait_req(1'b0, 40, n);
        check(n, 16, "interrupt period");
        check(rst_seen, r0, "no reset");
    endtask
    task automatic t_clear();
        logic [7:0] bad[4] = '{8'h00, 8'h55, `WDT_CODE_DISABLE ^ 8'h01, 8'hd2};
        int n;
        int t0;
        int t1;
        int r0;
        wait_req(1'b0, 40, n);
        t0 = now;
        repeat (3) @(posedge clock_i);
        wr(a_code, `WDT_CODE_CLEAR);
        t1 = now;
        wait_req(1'b0, 40, n);
        check((now - t0) % 4 == 0 && now - t0 > 16, 1'b1, "divider kept");
        check(now - t1 inside {[11:17]}, 1'b1, "shortest overflow");
        foreach (bad[i]) begin
            t0 = now;
            repeat (3) @(posedge clock_i);
            wr(a_code, bad[i]);
            wait_req(1'b0, 40, n);
            check(now - t0, 16, "other code");
        end
        wr(a_code, `WDT_CODE_CLEAR);
        r0 = irq_seen;
        repeat (6) begin
            repeat (5) @(posedge clock_i);
            wr(a_code, `WDT_CODE_CLEAR);
        end
        check(irq_seen, r0, "cleared in time");
    endtask
    task automatic t_halt();
        int n;
        int t0;
        int r0;
        for (int i = 0; i < 3; i++) begin
            wait_req(1'b0, 40, n);
            repeat (4) @(posedge clock_i);
            wr(a_code, `WDT_CODE_CLEAR);
            halt <= 3'b100 >> i;
            r0 = irq_seen;
            repeat (40) @(posedge clock_i);
            check(irq_seen, r0, "halted");
            halt <= 3'b000;
            t0 = now;
            wait_req(1'b0, 40, n);
            check(now - t0 inside {[11:15]}, 1'b1, "count resumed");
        end
    endtask
    task automatic t_disable();
        logic [31:0] r;
        int r0;
        int n;
        wr(a_code, `WDT_CODE_DISABLE);
        bus(1'b0, a_stat, 8'h0, r);
        check(r[1:0], 2'b11, "disable ignored while enabled");
        wr(a_code, `WDT_CODE_CLEAR);
        wr(a_cfg, 8'h06);
        bus(1'b0, a_stat, 8'h0, r);
        check(r[1:0], 2'b01, "still running");
        wr(a_code, `WDT_CODE_DISABLE);
        r0 = irq_seen;
        repeat (60) @(posedge clock_i);
        bus(1'b0, a_stat, 8'h0, r);
        check({r[7:5], r[0], irq_seen == r0}, 5'b10001, "held off");
        wr(a_stat, 8'h80);
        bus(1'b0, a_stat, 8'h0, r);
        check(r[7], 1'b0, "flag cleared");
        wr(a_cfg, 8'h0e);
        bus(1'b0, a_stat, 8'h0, r);
        check(r[0], 1'b1, "enabled again");
    endtask
    task automatic t_periods();
        int n;
        for (int m = 0; m < 3; m++) begin
            psel <= (m == 1);
            slow <= (m == 2);
            for (int t = 0; t < 4; t++) begin
                wr(a_cfg, {5'h01, 2'(t), 1'b0});
                wait_req(1'b0, 2200, n);
                wait_req(1'b0, 2200, n);
                check(n, m == 0 ? 1 << (FCX - 2 * t) : 4 << (FSX - 2 * t), "detection time");
            end
        end
    endtask

    // **********
    // main sequence and watchdog
    // **********
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset_route();
        t_clear();
        t_halt();
        t_disable();
        t_periods();
        end_sim();
    end
    // whole run needs at most about fifteen thousand cycles
    initial begin
        #4000000;
        check(1'b0, 1'b1, "run timeout");
        end_sim();
    end
endmodule
